// ===== logic/bwc_pkg.sv
// Purpose: Constants for the bridge window configuration header block
// Assumes: Byte-addressed configuration space, 32-bit dword accesses
// Notes:   Offsets are configuration byte addresses
`default_nettype none
package bwc_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] BWC_OFS_PF_BASE_LO   = 8'h24;
  localparam logic [7:0] BWC_OFS_PF_LIMIT     = 8'h26;
  localparam logic [7:0] BWC_OFS_PF_BASE_HI   = 8'h28;
  localparam logic [7:0] BWC_OFS_PF_LIMIT_HI  = 8'h2C;
  localparam logic [7:0] BWC_OFS_IO_BASE_HI   = 8'h30;
  localparam logic [7:0] BWC_OFS_IO_LIMIT_HI  = 8'h32;
  localparam logic [7:0] BWC_OFS_CAP_PTR      = 8'h34;
  localparam logic [7:0] BWC_OFS_INT_LINE     = 8'h3C;
  localparam logic [7:0] BWC_OFS_INT_PIN      = 8'h3D;
  // ==========================================================
  // Field positions
  localparam int BWC_ADDR_FLD_HI = 15;
  localparam int BWC_ADDR_FLD_LO = 4;
  // ==========================================================
  // Reset and fixed values
  localparam logic [15:0] BWC_RST_PF_LIMIT   = 16'h0001;
  localparam logic [15:0] BWC_RST_PF_BASE_LO = 16'h0001;
  localparam logic [3:0]  BWC_WIDE_ADDR_CODE = 4'h1;
  localparam logic [31:0] BWC_RST_HI_WORD    = 32'h0000_0000;
  localparam logic [15:0] BWC_RST_IO_HI      = 16'h0000;
  localparam logic [7:0]  BWC_CAP_PTR_VAL    = 8'h40;
  localparam logic [7:0]  BWC_RST_INT_LINE   = 8'hFF;
  localparam logic [7:0]  BWC_INT_PIN_VAL    = 8'h00;
  localparam logic [19:0] BWC_LOW_ONES       = 20'hFFFFF;
  localparam logic [19:0] BWC_LOW_ZERO       = 20'h00000;
  localparam logic [3:0]  BWC_RST_INT_N      = 4'hF;
  localparam logic [31:0] BWC_RST_RDATA      = 32'h0000_0000;
endpackage
`default_nettype wire

// ===== logic/bwc_win_if.sv
// Purpose: Carries one assembled window and a request address to the checker
// Assumes: Addresses are 64 bits wide
// Notes:   Producer drives bounds and address, checker answers hit
`default_nettype none
interface bwc_win_if;
  logic [63:0] bottom;
  logic [63:0] top;
  logic [63:0] addr;
  logic        hit;
  modport producer (output bottom, output top, output addr, input hit);
  modport checker_side (input bottom, input top, input addr, output hit);
endinterface
`default_nettype wire

// ===== logic/bwc_win_check.sv
// Purpose: Inclusive window compare for forwarding decisions
// Assumes: Bounds are already assembled to full width
// Notes:   Combinational; an inverted window never hits
`default_nettype none
module bwc_win_check (
  // Window
  bwc_win_if.checker_side win
);
  // ==========================================================
  // Compare
  // Inverted window is disabled, so software can park it safely
  assign win.hit = (win.bottom <= win.top) && (win.addr >= win.bottom)
                   && (win.addr <= win.top);
endmodule
`default_nettype wire

// ===== logic/bwc_top.sv
// Purpose: Prefetchable and I/O window extension registers of a bridge header
// Assumes: Dword config accesses with byte enables on the primary side
// Notes:   Window hits are combinational outputs for the forwarding logic
`default_nettype none
module bwc_top
  import bwc_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  // Configuration access
  input  wire logic        cfg_wr_i,
  input  wire logic        cfg_rd_i,
  input  wire logic [7:0]  cfg_addr_i,
  input  wire logic [3:0]  cfg_be_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic      [31:0] cfg_rdata_o,
  output logic             cfg_rvalid_o,
  // Forwarding check
  input  wire logic [63:0] fwd_addr_i,
  input  wire logic        fwd_is_io_i,
  output logic             fwd_hit_o,
  // Interrupt pass-through
  input  wire logic [3:0]  sec_int_n_i,
  output logic      [3:0]  pri_int_n_o
);
  import bwc_pkg::*;

  // ==========================================================
  // Register state
  logic [11:0] prefetch_bottom_addr_r;
  logic [11:0] prefetch_top_addr_r;
  logic [31:0] prefetch_base_high_word_r;
  logic [31:0] prefetch_limit_high_word_r;
  logic [15:0] io_bottom_addr_high_r;
  logic [15:0] io_top_addr_high_r;
  logic [7:0]  interrupt_line_scratch_r;
  logic [3:0]  sec_int_meta_r;
  logic [3:0]  sec_int_sync_r;
  logic [31:0] rdata_nxt;
  logic [3:0]  wide_addr_indicator;
  logic [7:0]  dw_addr;
  logic        pf_hit;
  logic        io_hit;
  logic        sel_pf_lo;
  logic        sel_pf_base_hi;
  logic        sel_pf_lim_hi;
  logic        sel_io_hi;
  logic        sel_int_line;

  // Fixed wide-address code and the dword the host points at
  assign wide_addr_indicator = BWC_WIDE_ADDR_CODE;
  assign dw_addr = {cfg_addr_i[7:2], 2'b00};

  // Dword decode; byte offsets inside one dword share a single select
  function automatic logic dw_match(input logic [7:0] a, input logic [7:0] ofs);
    dw_match = (a[7:2] == ofs[7:2]);
  endfunction

  // ==========================================================
  // Write selects; a read never disturbs any register
  assign sel_pf_lo      = cfg_wr_i && dw_match(cfg_addr_i, BWC_OFS_PF_BASE_LO);
  assign sel_pf_base_hi = cfg_wr_i && dw_match(cfg_addr_i, BWC_OFS_PF_BASE_HI);
  assign sel_pf_lim_hi  = cfg_wr_i && dw_match(cfg_addr_i, BWC_OFS_PF_LIMIT_HI);
  assign sel_io_hi      = cfg_wr_i && dw_match(cfg_addr_i, BWC_OFS_IO_BASE_HI);
  assign sel_int_line   = cfg_wr_i && dw_match(cfg_addr_i, BWC_OFS_INT_LINE);

  // Byte-lane merge, shared by the prefetch and I/O upper extension registers
  function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] nw,
                                      input logic en);
    lane = en ? nw : old;
  endfunction

  // ==========================================================
  // Prefetch base and limit low fields (dword 24h)
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      prefetch_bottom_addr_r <= BWC_RST_PF_BASE_LO[BWC_ADDR_FLD_HI:BWC_ADDR_FLD_LO];
      prefetch_top_addr_r    <= BWC_RST_PF_LIMIT[BWC_ADDR_FLD_HI:BWC_ADDR_FLD_LO];
    end else if (sel_pf_lo) begin
      // Low nibbles are read-only, so only the upper part of lane 0/2 lands
      if (cfg_be_i[0]) prefetch_bottom_addr_r[3:0]  <= cfg_wdata_i[7:4];
      if (cfg_be_i[1]) prefetch_bottom_addr_r[11:4] <= cfg_wdata_i[15:8];
      if (cfg_be_i[2]) prefetch_top_addr_r[3:0]     <= cfg_wdata_i[23:20];
      if (cfg_be_i[3]) prefetch_top_addr_r[11:4]    <= cfg_wdata_i[31:24];
    end
  end

  // ==========================================================
  // Upper 32-bit prefetch extensions
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      prefetch_base_high_word_r  <= BWC_RST_HI_WORD;
      prefetch_limit_high_word_r <= BWC_RST_HI_WORD;
    end else if (cfg_wr_i) begin
      // Each lane obeys its own enable, so partial dword writes merge
      for (int i = 0; i < 4; i++) begin
        if (sel_pf_base_hi)
          prefetch_base_high_word_r[i*8 +: 8] <=
            lane(prefetch_base_high_word_r[i*8 +: 8], cfg_wdata_i[i*8 +: 8], cfg_be_i[i]);
        if (sel_pf_lim_hi)
          prefetch_limit_high_word_r[i*8 +: 8] <=
            lane(prefetch_limit_high_word_r[i*8 +: 8], cfg_wdata_i[i*8 +: 8], cfg_be_i[i]);
      end
    end
  end

  // ==========================================================
  // Upper 16-bit I/O extensions
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      io_bottom_addr_high_r <= BWC_RST_IO_HI;
      io_top_addr_high_r    <= BWC_RST_IO_HI;
    end else if (sel_io_hi) begin
      // Base sits in the low half of the dword, limit in the high half
      io_bottom_addr_high_r[7:0]  <= lane(io_bottom_addr_high_r[7:0], cfg_wdata_i[7:0],
                                          cfg_be_i[0]);
      io_bottom_addr_high_r[15:8] <= lane(io_bottom_addr_high_r[15:8], cfg_wdata_i[15:8],
                                          cfg_be_i[1]);
      io_top_addr_high_r[7:0]     <= lane(io_top_addr_high_r[7:0], cfg_wdata_i[23:16],
                                          cfg_be_i[2]);
      io_top_addr_high_r[15:8]    <= lane(io_top_addr_high_r[15:8], cfg_wdata_i[31:24],
                                          cfg_be_i[3]);
    end
  end

  // ==========================================================
  // Interrupt line scratch; pin byte and cap pointer ignore writes
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      interrupt_line_scratch_r <= BWC_RST_INT_LINE;
    end else if (sel_int_line && cfg_be_i[0]) begin
      interrupt_line_scratch_r <= cfg_wdata_i[7:0];
    end
  end

  // ==========================================================
  // Read mux, one cycle of latency
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (dw_addr)
      BWC_OFS_PF_BASE_LO: rdata_nxt = {prefetch_top_addr_r, wide_addr_indicator,
                                       prefetch_bottom_addr_r, wide_addr_indicator};
      BWC_OFS_PF_BASE_HI: rdata_nxt = prefetch_base_high_word_r;
      BWC_OFS_PF_LIMIT_HI: rdata_nxt = prefetch_limit_high_word_r;
      BWC_OFS_IO_BASE_HI: rdata_nxt = {io_top_addr_high_r, io_bottom_addr_high_r};
      BWC_OFS_CAP_PTR: rdata_nxt = {24'h00_0000, BWC_CAP_PTR_VAL};
      BWC_OFS_INT_LINE: rdata_nxt = {16'h0000, BWC_INT_PIN_VAL,
                                     interrupt_line_scratch_r};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Read strobe echoed one edge later as the answer flag
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rvalid_o <= cfg_rd_i;
    end
  end

  // Read data held between reads, so a slow host may still take it late
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cfg_rdata_o <= BWC_RST_RDATA;
    end else if (cfg_rd_i) begin
      cfg_rdata_o <= rdata_nxt;
    end
  end

  // ==========================================================
  // Window assembly and forwarding decision
  bwc_win_if pf_win ();
  bwc_win_if io_win ();

  assign pf_win.bottom = {prefetch_base_high_word_r, prefetch_bottom_addr_r,
                          BWC_LOW_ZERO};
  assign pf_win.top    = {prefetch_limit_high_word_r, prefetch_top_addr_r,
                          BWC_LOW_ONES};
  assign pf_win.addr   = fwd_addr_i;
  // I/O upper bits sit above a 20-bit low part; 64-bit compare zero-extends them
  // Limitation: the low I/O base and limit bytes live elsewhere, so 1 MB granularity
  assign io_win.bottom = {28'h000_0000, io_bottom_addr_high_r, BWC_LOW_ZERO};
  assign io_win.top    = {28'h000_0000, io_top_addr_high_r, BWC_LOW_ONES};
  assign io_win.addr   = fwd_addr_i;

  // One comparator module keeps the inclusive rule in a single place
  bwc_win_check u_pf_chk (.win(pf_win.checker_side));
  bwc_win_check u_io_chk (.win(io_win.checker_side));

  assign pf_hit    = pf_win.hit;
  assign io_hit    = io_win.hit;
  // Combinational, so the forwarding logic decides in the same cycle
  assign fwd_hit_o = fwd_is_io_i ? io_hit : pf_hit;

  // ==========================================================
  // Interrupt pass-through; pins come from another domain
  // Two flops tame metastability; the third keeps the primary pins glitch free,
  // at the cost of one cycle that a level-sensitive interrupt never notices
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sec_int_meta_r <= BWC_RST_INT_N;
      sec_int_sync_r <= BWC_RST_INT_N;
      pri_int_n_o    <= BWC_RST_INT_N;
    end else begin
      sec_int_meta_r <= sec_int_n_i;
      sec_int_sync_r <= sec_int_meta_r;
      pri_int_n_o    <= sec_int_sync_r;
    end
  end

endmodule
`default_nettype wire

// ===== test/bwc_host_mdl.sv
// Purpose: Host config master, dword accesses
// Assumes: Tasks entered just after a rising edge
// Notes:   Idle write data is inverted so stale data never matches
`default_nettype none
module bwc_host_mdl (
  // Clock and read answer
  input  wire logic        mclk_i,
  input  wire logic        cfg_rvalid_i,
  input  wire logic [31:0] cfg_rdata_i,
  // Requests
  output logic             cfg_wr_o,
  output logic             cfg_rd_o,
  output logic      [7:0]  cfg_addr_o,
  output logic      [3:0]  cfg_be_o,
  output logic      [31:0] cfg_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet bus at time zero
  initial {cfg_wr_o, cfg_rd_o, cfg_addr_o, cfg_be_o, cfg_wdata_o} = '0;
  // Write held through its sampling edge
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] v);
    cfg_wr_o <= 1'b1;
    cfg_addr_o <= a;
    cfg_be_o <= b;
    cfg_wdata_o <= v;
    @(posedge mclk_i);
    cfg_wr_o <= 1'b0;
    cfg_wdata_o <= ~v;
  endtask
  // Read; data only counts while valid
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    cfg_rd_o <= 1'b1;
    cfg_addr_o <= a;
    @(posedge mclk_i);
    cfg_rd_o <= 1'b0;
    // Answer flag and data stand until the next edge; take both there
    @(posedge mclk_i);
    v = cfg_rvalid_i ? cfg_rdata_i : 'x;
  endtask
endmodule
`default_nettype wire

// ===== test/bwc_top_chk.sv
// Purpose: Port assertions for the window header
// Assumes: Read data lands one cycle after the strobe
// Notes:   Read-back checks need a write straight before the read
`default_nettype none
module bwc_top_chk (
  // Clock and reset
  input wire logic        mclk_i,
  input wire logic        srst_i,
  // Config bus
  input wire logic        cfg_wr_i,
  input wire logic        cfg_rd_i,
  input wire logic [7:0]  cfg_addr_i,
  input wire logic [3:0]  cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic [31:0] cfg_rdata_o,
  // Interrupts
  input wire logic [3:0]  sec_int_n_i,
  input wire logic [3:0]  pri_int_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // Full write then read of one dword
  sequence s_wrd(logic [5:0] w);
    cfg_wr_i && cfg_be_i == 4'hF && cfg_addr_i[7:2] == w ##1 cfg_rd_i && cfg_addr_i[7:2] == w;
  endsequence
  property p_lim;
    s_wrd(6'h09) |=> cfg_rdata_o == {$past(cfg_wdata_i[31:20], 2), 4'h1,
      $past(cfg_wdata_i[15:4], 2), 4'h1};
  endproperty
  a_lim: assert property (p_lim) else $error("limit readback");
  property p_nib;
    cfg_rd_i && cfg_addr_i[7:2] == 6'h09 |=> cfg_rdata_o[3:0] == 4'h1 && cfg_rdata_o[19:16] == 4'h1;
  endproperty
  a_nib: assert property (p_nib) else $error("wide nibble");
  property p_pfh;
    cfg_wr_i && cfg_be_i == 4'hF && cfg_addr_i[7:3] == 5'h05 ##1 cfg_rd_i
      && cfg_addr_i == $past(cfg_addr_i) |=> cfg_rdata_o == $past(cfg_wdata_i, 2);
  endproperty
  a_pfh: assert property (p_pfh) else $error("high word");
  property p_ioh;
    s_wrd(6'h0C) |=> cfg_rdata_o == $past(cfg_wdata_i, 2);
  endproperty
  a_ioh: assert property (p_ioh) else $error("io high");
  property p_cap;
    cfg_rd_i && cfg_addr_i[7:2] == 6'h0D |=> cfg_rdata_o == 32'h0000_0040;
  endproperty
  a_cap: assert property (p_cap) else $error("cap pointer");
  property p_line;
    s_wrd(6'h0F) |=> cfg_rdata_o[7:0] == $past(cfg_wdata_i[7:0], 2);
  endproperty
  a_line: assert property (p_line) else $error("int line");
  property p_pin;
    cfg_rd_i && cfg_addr_i[7:2] == 6'h0F |=> cfg_rdata_o[15:8] == 8'h00;
  endproperty
  a_pin: assert property (p_pin) else $error("int pin");
  // Three-edge interrupt pipe; the first three edges after reset still show idle
  property p_int;
    !$past(srst_i) && !$past(srst_i, 2) && !$past(srst_i, 3) |->
      pri_int_n_o == $past(sec_int_n_i, 3);
  endproperty
  a_int: assert property (p_int) else $error("int pass");
  c_lim: cover property (s_wrd(6'h09));
  c_ioh: cover property (s_wrd(6'h0C));
  c_int: cover property ($fell(pri_int_n_o[0]));
endmodule
bind bwc_top bwc_top_chk bwc_top_chk_i (.mclk_i(mclk_i), .srst_i(srst_i), .cfg_wr_i(cfg_wr_i),
  .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
  .cfg_rdata_o(cfg_rdata_o), .sec_int_n_i(sec_int_n_i), .pri_int_n_o(pri_int_n_o));
`default_nettype wire

// ===== test/tb_bwc_top.sv
// Purpose: Self-checking bench for the window header
// Assumes: 125 MHz clock, reset held 16 cycles
// Notes:   Hits are sampled at the falling edge
`default_nettype none
module tb_bwc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        wr, rd, rv, io = 1'b0, hit;
  logic [7:0]  ad;
  logic [3:0]  be, pri, sec = 4'hF;
  logic [31:0] wd, rdat, d;
  logic [63:0] fa = '0;
  int          miscompares = 0;
  int          total_checks = 0;
  // Core clock
  always #4 mclk_i = ~mclk_i;
  bwc_host_mdl host_i (.mclk_i(mclk_i), .cfg_rvalid_i(rv), .cfg_rdata_i(rdat), .cfg_wr_o(wr),
    .cfg_rd_o(rd), .cfg_addr_o(ad), .cfg_be_o(be), .cfg_wdata_o(wd));
  bwc_top bwc_top_i (.mclk_i(mclk_i), .srst_i(srst_i), .cfg_wr_i(wr), .cfg_rd_i(rd),
    .cfg_addr_i(ad), .cfg_be_i(be), .cfg_wdata_i(wd), .cfg_rdata_o(rdat), .cfg_rvalid_o(rv),
    .fwd_addr_i(fa), .fwd_is_io_i(io), .fwd_hit_o(hit), .sec_int_n_i(sec), .pri_int_n_o(pri));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    host_i.rd(a, d);
    chk("rdata", e, d);
  endtask
  // Probe held a full cycle so the compare sees settled logic
  task automatic fw(input logic i, input logic [63:0] a, input logic e);
    io <= i;
    fa <= a;
    @(negedge mclk_i);
    chk("hit", {31'h0, e}, {31'h0, hit});
    @(posedge mclk_i);
  endtask
  task automatic t_pf;
    rc(8'h24, 32'h0001_0001);
    host_i.wr(8'h24, 4'hF, 32'h0020_0010);
    rc(8'h24, 32'h0021_0011);
    host_i.wr(8'h28, 4'hF, 32'h1);
    rc(8'h28, 32'h1);
    host_i.wr(8'h2C, 4'hF, 32'h1);
    rc(8'h2C, 32'h1);
    fw(1'b0, 64'h1_0010_0000, 1'b1);
    fw(1'b0, 64'h1_002F_FFFF, 1'b1);
    fw(1'b0, 64'h1_0030_0000, 1'b0);
    fw(1'b0, 64'h1_000F_FFFF, 1'b0);
    fw(1'b0, 64'h2_0020_0000, 1'b0);
    host_i.wr(8'h2C, 4'hF, 32'h0);
    fw(1'b0, 64'h1_0020_0000, 1'b0);
    host_i.wr(8'h28, 4'h5, 32'hAABB_CCDD);
    rc(8'h28, 32'h00BB_00DD);
    host_i.wr(8'h2C, 4'hA, 32'hAABB_CCDD);
    rc(8'h2C, 32'hAA00_CC00);
    host_i.wr(8'h24, 4'h4, 32'h00F0_0000);
    rc(8'h24, 32'h00F1_0011);
    fw(1'b0, 64'h00BB_00DD_0010_0000, 1'b1);
  endtask
  task automatic t_io;
    rc(8'h30, 32'h0);
    host_i.wr(8'h30, 4'hF, 32'h0003_0002);
    rc(8'h30, 32'h0003_0002);
    fw(1'b1, 64'h0020_0000, 1'b1);
    fw(1'b1, 64'h003F_FFFF, 1'b1);
    fw(1'b1, 64'h0040_0000, 1'b0);
    fw(1'b1, 64'h001F_FFFF, 1'b0);
    host_i.wr(8'h30, 4'h2, 32'h0000_5500);
    rc(8'h30, 32'h0003_5502);
    fw(1'b1, 64'h0020_0000, 1'b0);
  endtask
  // Read-only places and the unmapped hole shrug off writes
  task automatic t_ro;
    rc(8'h3C, 32'h0000_00FF);
    host_i.wr(8'h34, 4'hF, 32'hFFFF_FFFF);
    rc(8'h34, 32'h0000_0040);
    host_i.wr(8'h3C, 4'hF, 32'hFFFF_FF5A);
    rc(8'h3C, 32'h0000_005A);
    host_i.wr(8'h40, 4'hF, 32'h1234_5678);
    rc(8'h40, 32'h0);
  endtask
  task automatic t_int;
    sec <= 4'hA;
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    chk("pri", 32'hF, {28'h0, pri});
    @(posedge mclk_i);
    @(negedge mclk_i);
    chk("pri", 32'hA, {28'h0, pri});
  endtask
  // Mid-run reset restores every register while the interrupts stay asserted
  task automatic t_rst;
    @(posedge mclk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
    chk("pri", 32'hF, {28'h0, pri});
    @(posedge mclk_i);
    srst_i <= 1'b0;
    rc(8'h24, 32'h0001_0001);
    rc(8'h28, 32'h0);
    rc(8'h2C, 32'h0);
    rc(8'h30, 32'h0);
    rc(8'h3C, 32'h0000_00FF);
    chk("pri", 32'hA, {28'h0, pri});
  endtask
  task automatic close_out;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk_i);
    srst_i <= 1'b0;
    t_pf();
    t_io();
    t_ro();
    t_int();
    t_rst();
    close_out();
  end
  // Watchdog far past the fewer than a hundred cycles needed
  initial begin
    #20us;
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
